// ### hdl/qep_defines.svh
`ifndef QEP_DEFINES_SVH
`define QEP_DEFINES_SVH
// ----------------------------------------
// Mode codes
// ----------------------------------------
`define QEP_MODE_X2_INDEX 3'h4
`define QEP_MODE_X2_MATCH 3'h5
`define QEP_MODE_X4_INDEX 3'h6
`define QEP_MODE_X4_MATCH 3'h7
// ----------------------------------------
// Widths, reset values, filter timing
// ----------------------------------------
`define QEP_CNT_W 16
`define QEP_CNT_ALL_ONES 16'hffff
`define QEP_CNT_ZERO 16'h0000
`define QEP_CNT_ONE 16'h0001
`define QEP_FLT_STABLE 2'h3
`define QEP_FLT_ZERO 2'h0
`define QEP_FLT_ONE 2'h1
`define QEP_DIV_ZERO 8'h00
`define QEP_DIV_ONE 8'h01
`endif

// ### hdl/qep_pkg.sv
package qep_pkg;
  // Decoder operating mode
  typedef enum logic [1:0] {
    QEP_OFF,
    QEP_X2,
    QEP_X4
  } qep_meas_type;
endpackage

// ### hdl/qep_encoder.sv
`timescale 1ns/1ps
`include "qep_defines.svh"
// What this block does
// (RQ1) A leading B means positive direction
// (RQ2) Encoder pulses index with both phases low
// (RQ3) 16-bit counter steps by decoded direction
// (RQ4) Index modes: hit 0xFFFF/max+1 flags error
// (RQ5) Error disable bit suppresses error interrupt
// (RQ6) Keep counting after error, no wrap irq
// (RQ7) Error flag sticky until software clears
// (RQ8) Index reset enable resets counter on index
// (RQ9) Index interrupts in index modes, wrap never does
// (RQ10) Direction mirrored to read-only status bit
// (RQ11) Direction pin driven only when enabled
// (RQ12) Three-bit mode field selects mode, reset
// (RQ13) x2 counts phase A edges only
// (RQ14) x2: code 100 index, 101 match reset
// (RQ15) x4 counts edges of both phases
// (RQ16) x4: code 110 index, 111 match reset
// (RQ17) Filter output changes after three stable
// (RQ18) Filter clock divided by three-bit field
// (RQ19) Filtered inputs pass only when enabled
// (RQ20) Shared interrupt flag set, software clears
// (RQ21) Match mode: wrap to zero or max
module qep_encoder
  import qep_pkg::*;
#(
  parameter int CNT_W = `QEP_CNT_W
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic phase_a_input_in,
  input wire logic phase_b_input_in,
  input wire logic index_input_in,
  input wire logic [2:0] encoder_mode_select_in,
  input wire logic index_reset_enable_in,
  input wire logic direction_output_enable_in,
  input wire logic [2:0] filter_clock_divide_in,
  input wire logic filter_output_enable_in,
  input wire logic count_error_irq_disable_in,
  input wire logic [CNT_W-1:0] max_count_in,
  input wire logic pos_write_in,
  input wire logic [CNT_W-1:0] pos_wdata_in,
  input wire logic count_error_clear_in,
  input wire logic encoder_irq_flag_clear_in,
  output logic [CNT_W-1:0] position_count_out,
  output logic count_error_flag_out,
  output logic count_direction_out,
  output logic encoder_irq_flag_out,
  output logic direction_pin_out,
  output logic direction_pin_oe_b_out
);

  // ----------------------------------------
  // Filter clock divider
  // ----------------------------------------
  logic [7:0] div_cnt_ff; // Divider count
  logic [7:0] div_lim; // Divide ratio minus one
  logic flt_tick; // One-cycle filter enable

  // Ratio 1,2,4..128 from the divide field
  assign div_lim = (`QEP_DIV_ONE << filter_clock_divide_in) - `QEP_DIV_ONE;
  assign flt_tick = (div_cnt_ff >= div_lim);

  // Free-running divider
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      div_cnt_ff <= `QEP_DIV_ZERO;
    end else if (flt_tick) begin // [RQ18]
      div_cnt_ff <= `QEP_DIV_ZERO;
    end else begin
      div_cnt_ff <= div_cnt_ff + `QEP_DIV_ONE;
    end
  end

  // ----------------------------------------
  // Noise filters: A, B, index
  // ----------------------------------------
  logic [2:0] raw_in; // Raw pins
  logic [2:0] flt_ff; // Filtered levels
  logic [2:0] sel; // Levels seen by decoder

  assign raw_in = {index_input_in, phase_b_input_in, phase_a_input_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flt
      logic [1:0] stab_ff; // Consecutive stable ticks
      // Output follows only after three stable filter ticks
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          stab_ff <= `QEP_FLT_ZERO;
          flt_ff[gi] <= raw_in[gi]; // Start at pin level, no false edge
        end else if (flt_tick) begin
          if (raw_in[gi] == flt_ff[gi]) begin
            stab_ff <= `QEP_FLT_ZERO;
          end else if (stab_ff == `QEP_FLT_STABLE - `QEP_FLT_ONE) begin // [RQ17]
            stab_ff <= `QEP_FLT_ZERO;
            flt_ff[gi] <= raw_in[gi];
          end else begin
            stab_ff <= stab_ff + `QEP_FLT_ONE;
          end
        end
      end
    end
  endgenerate

  // Bypass filter unless enabled
  assign sel = filter_output_enable_in ? flt_ff : raw_in; // [RQ19]

  // ----------------------------------------
  // Edge detect and direction decode
  // ----------------------------------------
  logic [2:0] prev_ff; // Previous levels
  logic a_edge; // Phase A toggled
  logic b_edge; // Phase B toggled
  logic idx_rise; // Index detected
  logic nxt_dir; // Decoded direction
  logic dir_ff; // Direction state
  qep_meas_type meas; // Active measurement mode

  assign a_edge = sel[0] ^ prev_ff[0];
  assign b_edge = sel[1] ^ prev_ff[1];
  assign idx_rise = sel[2] & ~prev_ff[2];

  // Mode decode from the three-bit field
  always_comb begin
    case (encoder_mode_select_in) // [RQ12]
      `QEP_MODE_X2_INDEX, `QEP_MODE_X2_MATCH: meas = QEP_X2;
      `QEP_MODE_X4_INDEX, `QEP_MODE_X4_MATCH: meas = QEP_X4;
      default: meas = QEP_OFF;
    endcase
  end

  // A leads B: A edge with A!=B, or B edge with A==B means up
  always_comb begin
    nxt_dir = dir_ff;
    if (a_edge && !b_edge) begin
      nxt_dir = sel[0] ^ sel[1]; // [RQ1]
    end else if (b_edge && !a_edge) begin
      nxt_dir = ~(sel[0] ^ sel[1]); // [RQ1]
    end
  end

  // Level history
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      prev_ff <= sel; // Track pin level so release gives no false edge
    end else begin
      prev_ff <= sel;
    end
  end

  // Direction register
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      dir_ff <= 1'b0;
    end else begin
      dir_ff <= nxt_dir;
    end
  end

  // ----------------------------------------
  // Count pulse and counter
  // ----------------------------------------
  logic step; // Count pulse
  logic idx_mode; // Index reset mode
  logic [CNT_W-1:0] pos_ff; // Position counter
  logic [CNT_W-1:0] nxt_pos;
  logic err_hit; // Error compare hit
  logic idx_evt; // Qualified index

  // x2 sees A only, x4 sees A and B
  assign step = (meas == QEP_X2) ? a_edge // [RQ13]
              : (meas == QEP_X4) ? (a_edge | b_edge) : 1'b0; // [RQ15]
  assign idx_mode = (encoder_mode_select_in == `QEP_MODE_X2_INDEX) ||
                    (encoder_mode_select_in == `QEP_MODE_X4_INDEX);
  assign idx_evt = idx_mode && idx_rise;
  // Error compare in index modes only
  assign err_hit = idx_mode && ((pos_ff == `QEP_CNT_ALL_ONES) ||
                   (pos_ff == max_count_in + `QEP_CNT_ONE)); // [RQ4]

  // Next position
  always_comb begin
    nxt_pos = pos_ff;
    if (idx_evt && index_reset_enable_in) begin
      nxt_pos = `QEP_CNT_ZERO; // [RQ8] [RQ14] [RQ16]
    end else if (step) begin
      if (idx_mode) begin
        // Natural wrap, no interrupt
        nxt_pos = nxt_dir ? pos_ff + `QEP_CNT_ONE : pos_ff - `QEP_CNT_ONE; // [RQ3] [RQ6]
      end else if (nxt_dir) begin
        nxt_pos = (pos_ff == max_count_in) ? `QEP_CNT_ZERO : pos_ff + `QEP_CNT_ONE; // [RQ21]
      end else begin
        nxt_pos = (pos_ff == `QEP_CNT_ZERO) ? max_count_in : pos_ff - `QEP_CNT_ONE; // [RQ21]
      end
    end
  end

  // Position register, software write wins
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pos_ff <= `QEP_CNT_ZERO;
    end else if (pos_write_in) begin
      pos_ff <= pos_wdata_in;
    end else begin
      pos_ff <= nxt_pos;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic err_ff; // Count error flag
  logic irq_ff; // Shared interrupt flag
  logic irq_evt; // Any interrupt event
  logic err_new; // Fresh error

  assign err_new = err_hit && !err_ff;
  assign irq_evt = idx_evt || (err_new && !count_error_irq_disable_in); // [RQ5] [RQ9]

  // Sticky error flag, set beats clear
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      err_ff <= 1'b0;
    end else if (err_hit) begin
      err_ff <= 1'b1; // [RQ4]
    end else if (count_error_clear_in) begin
      err_ff <= 1'b0; // [RQ7]
    end
  end

  // Shared interrupt flag, set beats clear
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      irq_ff <= 1'b0;
    end else if (irq_evt) begin
      irq_ff <= 1'b1; // [RQ20]
    end else if (encoder_irq_flag_clear_in) begin
      irq_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign position_count_out = pos_ff;
  assign count_error_flag_out = err_ff;
  assign count_direction_out = dir_ff; // [RQ10]
  assign encoder_irq_flag_out = irq_ff;
  assign direction_pin_out = dir_ff;
  assign direction_pin_oe_b_out = ~direction_output_enable_in; // [RQ11]

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_index_seen;
    idx_evt && index_reset_enable_in && !pos_write_in;
  endsequence

  idx_reset_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ8]
    s_index_seen |=> pos_ff == `QEP_CNT_ZERO) else $error("Index did not reset counter");
  err_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ4]
    err_hit |=> err_ff) else $error("Error flag not set on hit");
  err_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ7]
    err_ff && !count_error_clear_in |=> err_ff) else $error("Error flag dropped alone");
  count_error_irq_disable_mask_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ5]
    !irq_ff && !idx_evt && count_error_irq_disable_in |=> !irq_ff) else $error("Masked error raised irq");
  idx_irq_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ9]
    idx_evt |=> irq_ff) else $error("Index did not raise irq");
  x2_no_b_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ13]
    meas == QEP_X2 && !a_edge && !idx_evt && !pos_write_in |=> $stable(pos_ff))
    else $error("x2 counted without A edge");
  x4_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ15]
    meas == QEP_X4 && b_edge && !a_edge && !idx_evt && !pos_write_in && max_count_in != `QEP_CNT_ZERO
    |=> !$stable(pos_ff))
    else $error("x4 missed B edge");
  up_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ3]
    step && nxt_dir && idx_mode && !idx_evt && !pos_write_in |=> pos_ff == $past(pos_ff) + `QEP_CNT_ONE)
    else $error("Up count wrong");
  wrap_up_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ21]
    step && nxt_dir && !idx_mode && pos_ff == max_count_in && !pos_write_in |=> pos_ff == `QEP_CNT_ZERO)
    else $error("Match wrap wrong");
  dir_pin_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ11]
    direction_pin_oe_b_out == !direction_output_enable_in && direction_pin_out == count_direction_out)
    else $error("Direction pin wrong");

  // ----------------------------------------
  // Further checks: direction, wraps, flags
  // ----------------------------------------
  // Down step in a match mode from zero
  sequence s_down_from_zero;
    step && !nxt_dir && !idx_mode && !pos_write_in && pos_ff == `QEP_CNT_ZERO;
  endsequence

  // Clear strobe with no set pending
  sequence s_irq_clear_only;
    encoder_irq_flag_clear_in && !irq_evt;
  endsequence

  // A toggles into unequal phases
  sequence s_a_leads;
    a_edge && !b_edge && (sel[0] != sel[1]);
  endsequence

  // B toggles into unequal phases
  sequence s_b_leads;
    b_edge && !a_edge && (sel[0] != sel[1]);
  endsequence

  // Direction decode
  dir_up_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ1]
    s_a_leads |=> dir_ff) else $error("A leading B not decoded as up");
  dir_down_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ1]
    s_b_leads |=> !dir_ff) else $error("B leading A not decoded as down");

  // Counter steps and wraps
  down_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ3]
    step && !nxt_dir && idx_mode && !idx_evt && !pos_write_in |=> pos_ff == $past(pos_ff) - `QEP_CNT_ONE)
    else $error("Down count wrong");
  wrap_down_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ21]
    s_down_from_zero |=> pos_ff == $past(max_count_in)) else $error("Match underflow wrong");
  idx_keep_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ8]
    idx_evt && !index_reset_enable_in && !step && !pos_write_in |=> $stable(pos_ff)) else $error("Index reset while off");

  // Flags
  err_irq_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ4]
    err_new && !count_error_irq_disable_in |=> irq_ff) else $error("Error did not raise irq");
  no_wrap_irq_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ6]
    !irq_ff && !idx_evt && !err_new |=> !irq_ff) else $error("Wrap raised irq");
  err_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ7]
    count_error_clear_in && !err_hit |=> !err_ff) else $error("Error flag not cleared");
  irq_set_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ20]
    irq_evt |=> irq_ff) else $error("Irq flag not set");
  irq_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ20]
    s_irq_clear_only |=> !irq_ff) else $error("Irq flag not cleared");

  // Mode field and filter
  off_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ12]
    !encoder_mode_select_in[2] && !pos_write_in |=> $stable(pos_ff)) else $error("Counter moved while off");
  flt_wait_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ17]
    $past(rst_b_in) && !$stable(flt_ff[0]) |-> $past(flt_tick) && $past(g_flt[0].stab_ff) == 2'h2)
    else $error("Phase A filter changed too early");
  flt_wait_b_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [RQ17]
    $past(rst_b_in) && !$stable(flt_ff[1]) |-> $past(flt_tick) && $past(g_flt[1].stab_ff) == 2'h2)
    else $error("Phase B filter changed too early");

endmodule // qep_encoder

// ### test/qep_enc_model.sv
`timescale 1ns/1ps
// Encoder model: two phases in quadrature plus once-per-turn index
module qep_enc_model (
  input wire logic clk_in,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic idx_in,
  output logic phase_a_out,
  output logic phase_b_out,
  output logic index_out
);
  logic [1:0] st_ff = 2'h0; // Quarter-cycle position
  // One quarter step after the edge; up means A leads B
  always @(posedge clk_in) begin
    if (step_in) begin
      st_ff <= dir_in ? st_ff + 2'h1 : st_ff - 2'h1;
    end
  end
  // Phase pattern 00,10,11,01 when moving up
  assign phase_a_out = st_ff[1] ^ st_ff[0];
  assign phase_b_out = st_ff[1];
  // Index only seen while both phases are low
  assign index_out = idx_in & (st_ff == 2'h0);
endmodule // qep_enc_model

// ### test/qep_encoder_tb.sv
`timescale 1ns/1ps
module qep_encoder_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0, rst_b = 1'b0, step = 1'b0, dir = 1'b0, idx = 1'b0;
  logic pw = 1'b0, cec = 1'b0, ifc = 1'b0, ire = 1'b0, doe = 1'b0, fen = 1'b0, count_error_irq_disable = 1'b0;
  logic [2:0] mode = 3'h0, fdiv = 3'h0;
  logic [15:0] maxc = 16'hffff, pwd = 16'h0000, pos;
  logic pa, pb, pi, cerr, cdir, irq, pin, oe_b;
  int num_errors = 0, checks = 0;
  typedef struct {logic [2:0] m; logic d; logic [15:0] e; logic dc;} qep_row_type;
  qep_row_type rows [6] = '{'{3'h6, 1'b1, 16'h0104, 1'b1}, '{3'h6, 1'b0, 16'h00fc, 1'b1},
    '{3'h4, 1'b1, 16'h0102, 1'b1}, '{3'h5, 1'b0, 16'h00fe, 1'b1},
    '{3'h7, 1'b1, 16'h0104, 1'b1}, '{3'h0, 1'b1, 16'h0100, 1'b0}};
  // Clock, 10 ns period
  initial begin
    forever #5 clk = ~clk;
  end
  qep_enc_model i_qep_enc_model (.clk_in(clk), .step_in(step), .dir_in(dir), .idx_in(idx),
    .phase_a_out(pa), .phase_b_out(pb), .index_out(pi));
  qep_encoder i_qep_encoder (.clk_in(clk), .rst_b_in(rst_b), .phase_a_input_in(pa),
    .phase_b_input_in(pb), .index_input_in(pi), .encoder_mode_select_in(mode),
    .index_reset_enable_in(ire), .direction_output_enable_in(doe), .filter_clock_divide_in(fdiv),
    .filter_output_enable_in(fen), .count_error_irq_disable_in(count_error_irq_disable), .max_count_in(maxc),
    .pos_write_in(pw), .pos_wdata_in(pwd), .count_error_clear_in(cec),
    .encoder_irq_flag_clear_in(ifc), .position_count_out(pos), .count_error_flag_out(cerr),
    .count_direction_out(cdir), .encoder_irq_flag_out(irq), .direction_pin_out(pin),
    .direction_pin_oe_b_out(oe_b));
  // ----------------------------------------
  // Helper tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e, input string w);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e, input string w);
    chk16({15'h0000, g}, {15'h0000, e}, w);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rst(input int n);
    rst_b = 1'b0;
    tick(n);
    rst_b = 1'b1;
    tick(1);
  endtask
  // Pulse a single-cycle strobe
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic load(input logic [15:0] v);
    pwd = v;
    pulse(pw);
  endtask
  task automatic move(input logic d, input int n);
    repeat (n) begin
      dir = d;
      pulse(step);
      tick(3);
    end
  endtask
  // Bounded wait for a count, then compare
  task automatic wait_pos(input logic [15:0] e, input int lim);
    for (int i = 0; i < lim && pos !== e; i++) @(negedge clk);
    chk16(pos, e, "position");
    if (pos !== e) final_report();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst(12);
    chk16(pos, 16'h0000, "reset count");
    chk1(cerr | irq | cdir, 1'b0, "reset flags");
    $display("test reset done");
    foreach (rows[k]) begin
      load(16'h0100);
      mode = rows[k].m;
      move(rows[k].d, 4);
      wait_pos(rows[k].e, 20);
      if (rows[k].dc) chk1(cdir, rows[k].d, "direction");
    end
    $display("test table done");
    maxc = 16'h0003;
    for (int k = 0; k < 2; k++) begin
      mode = k ? 3'h7 : 3'h5;
      load(16'h0003);
      move(1'b1, 1);
      wait_pos(16'h0000, 20);
      move(1'b0, 1);
      wait_pos(16'h0003, 20);
    end
    doe = 1'b1;
    tick(1);
    chk1(oe_b, 1'b0, "pin enable");
    chk1(pin, 1'b0, "pin value");
    doe = 1'b0;
    tick(1);
    chk1(oe_b, 1'b1, "pin release");
    rst(2);
    chk16(pos, 16'h0000, "mid reset");
    $display("test match and pin done");
    mode = 3'h6;
    maxc = 16'h0010;
    for (int k = 0; k < 4; k++) begin
      mode = k[1] ? 3'h6 : 3'h4;
      ire = !k[0];
      load(16'h0050);
      idx = 1'b1;
      tick(2);
      idx = 1'b0;
      tick(4);
      chk16(pos, k[0] ? 16'h0050 : 16'h0000, "index reset");
      chk1(irq, 1'b1, "index irq");
      pulse(ifc);
      tick(2);
      chk1(irq, 1'b0, "irq clear");
    end
    $display("test index done");
    count_error_irq_disable = 1'b1;
    load(16'h0010);
    move(1'b1, 1);
    wait_pos(16'h0011, 20);
    tick(2);
    chk1(cerr, 1'b1, "error up");
    chk1(irq, 1'b0, "error masked");
    move(1'b1, 1);
    wait_pos(16'h0012, 20);
    pulse(cec);
    tick(2);
    chk1(cerr, 1'b0, "error clear");
    count_error_irq_disable = 1'b0;
    load(16'h0000);
    move(1'b0, 1);
    wait_pos(16'hffff, 20);
    tick(2);
    chk1(cerr & irq, 1'b1, "error down");
    pulse(ifc);
    move(1'b1, 1);
    wait_pos(16'h0000, 20);
    tick(2);
    chk1(irq, 1'b0, "no wrap irq");
    $display("test error done");
    fen = 1'b1;
    load(16'h0200);
    for (int k = 0; k < 2; k++) begin
      fdiv = k ? 3'h3 : 3'h0;
      dir = 1'b1;
      pulse(step);
      tick(k ? 12 : 2);
      chk16(pos, 16'h0200 + k, "filter hold");
      wait_pos(16'h0201 + k, 80);
    end
    $display("test filter done");
    final_report();
  end
endmodule // qep_encoder_tb
